// file: vpn_pkg.sv
// constants, register map and carrier types for the interrupt priority and nesting block
package vpn_pkg;

    // widths and counts
    localparam int unsigned ADDR_W      = 32;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned NUM_SRC     = 28;   // fast vector numbers 0..27
    localparam int unsigned NUM_IRQ_SRC = 22;   // normal vector numbers 0..21
    localparam int unsigned LVL_W       = 3;
    localparam int unsigned NUM_LVL     = 8;
    localparam int unsigned SRC_W       = 5;
    localparam int unsigned BASE_W      = 16;
    localparam int unsigned STAT_W      = 8;
    localparam int unsigned NUM_PRIO2   = 6;

    // register byte addresses
    localparam logic [31:0] OFF_VEC_BASE = 32'hffff0014;
    localparam logic [31:0] OFF_NVEC     = 32'hffff001c;
    localparam logic [31:0] OFF_PRIO2    = 32'hffff0028;
    localparam logic [31:0] OFF_NCTRL    = 32'hffff0030;
    localparam logic [31:0] OFF_NSTAT    = 32'hffff003c;
    localparam logic [31:0] OFF_FVEC     = 32'hffff011c;
    localparam logic [31:0] OFF_FSTAT    = 32'hffff013c;

    // reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [31:0] RD_UNMAP  = 32'h0000_0000;

    // nesting control fields
    localparam int unsigned NEST_NORMAL_BIT = 0;
    localparam int unsigned NEST_FAST_BIT   = 1;
    localparam logic [1:0]  NCTRL_MASK      = 2'h3;

    // priority group two: field lsb and the source number each field steers
    localparam logic [31:0] PRIO2_MASK = 32'h0077_7777;
    localparam int unsigned PRIO2_LSB [NUM_PRIO2] = '{0, 4, 8, 12, 16, 20};
    localparam int unsigned PRIO2_SRC [NUM_PRIO2] = '{16, 17, 18, 19, 20, 21};

    // vector word layout
    localparam int unsigned VEC_SRC_LSB  = 2;
    localparam int unsigned VEC_BASE_LSB = 7;

    // register bus request from the processor side
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } vpn_bus_req_s;

    // result of a priority search
    typedef struct packed {
        logic             valid;
        logic [SRC_W-1:0] src;
        logic [LVL_W-1:0] level;
    } vpn_pick_s;

endpackage : vpn_pkg

// file: vpn_prio_pick.sv
// priority search: finds the best unblocked pending source
`timescale 1ns/10ps

module vpn_prio_pick (
    input  wire logic [27:0]       pend_in,     // pending sources, one bit each
    input  wire logic [83:0]       lvl_in,      // 3-bit level per source
    input  wire logic              use_lvl_in,  // high: levels count, low: all level 0
    input  wire logic [7:0]        block_in,    // blocked levels, one bit each
    output vpn_pkg::vpn_pick_s     pick_out     // chosen source, level, valid
);

    // scan upward; strict compare keeps the lowest number among equal levels
    always_comb begin
        logic [3:0] best;
        logic [2:0] lv;
        best     = 4'h8;
        lv       = 3'h0;
        pick_out = '0;
        for (int i = 0; i < int'(vpn_pkg::NUM_SRC); i++) begin
            lv = use_lvl_in ? lvl_in[i*3 +: 3] : 3'h0;
            if (pend_in[i] && !block_in[lv] && ({1'b0, lv} < best)) begin
                best           = {1'b0, lv};
                pick_out.valid = 1'b1;
                pick_out.src   = 5'(i);
                pick_out.level = lv;
            end
        end
    end

endmodule : vpn_prio_pick

// file: vpn_nest_ctrl.sv
// priority levels, nesting control, nesting status and vector registers of the interrupt controller
`timescale 1ns/10ps

// Overview of operation
// - group two register holds six 3-bit levels at 22:20,18:16,14:12,10:8,6:4,2:0.
// - nesting control bit 0 enables nesting and level handling for normal interrupts.
// - nesting control bit 1 enables nesting and level handling for fast interrupts.
// - with both bits clear interrupts still flow, levels ignored, no nesting.
// - with both bits clear a pending fast request beats a normal one.
// - normal vector read with nesting on sets normal status bit at active level.
// - a set status bit blocks its level and all lower levels.
// - writing normal status clears only its highest-priority set bit.
// - fast vector read with fast nesting on sets fast status bit at level.
// - writing fast status clears one bit, highest-priority first.
// - fast vector: zero 31:23, base 22:7, source 6:2, zero 1:0.
// - source field carries plain binary source number, second timer gives 00100.
// - normal vector holds source 0..21 at 6:2 and base at 22:7.
// - 16-bit vector base supplies upper field of both vector registers.
module vpn_nest_ctrl (
    input  wire logic                clk_in,       // core clock, 100 MHz
    input  wire logic                arst_n_in,    // asynchronous reset, active low
    input  wire logic                ce_in,        // clock enable, low freezes all state
    input  wire vpn_pkg::vpn_bus_req_s bus_in,     // register bus request
    output logic [31:0]              rdata_out,    // read data, cycle after read strobe
    input  wire logic [27:0]         irq_pend_in,  // enabled pending normal sources
    input  wire logic [27:0]         fiq_pend_in,  // enabled pending fast sources
    input  wire logic [83:0]         lvl_in,       // levels from the other priority registers
    output logic                     irq_req_out,  // normal interrupt request to core
    output logic                     fiq_req_out   // fast interrupt request to core
);

    // clear the lowest set bit, i.e. the highest-priority nested level
    function automatic logic [7:0] clr_top(input logic [7:0] s);
        clr_top = s & (s - 8'h01);
    endfunction : clr_top

    // level i is blocked once any status bit at i or above in priority is set
    function automatic logic [7:0] block_of(input logic [7:0] s);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < 8; i++) begin
            b[i] = |(s & 8'((16'h0002 << i) - 16'h0001));
        end
        block_of = b;
    endfunction : block_of

    // vector word from base and source number
    function automatic logic [31:0] mk_vec(input logic [15:0] base, input logic [4:0] src);
        mk_vec = {9'h000, base, src, 2'h0};
    endfunction : mk_vec

    // one-hot of a level
    function automatic logic [7:0] lvl_bit(input logic [2:0] lv);
        lvl_bit = 8'h01 << lv;
    endfunction : lvl_bit

    // registers
    logic [15:0] base_q;
    logic [31:0] prio2_q;
    logic [1:0]  nctrl_q;
    logic [7:0]  nstat_q;
    logic [7:0]  nstat_d;
    logic [7:0]  fstat_q;
    logic [7:0]  fstat_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        irq_req_q;
    logic        fiq_req_q;

    // decoded strobes; strobes are ignored while the clock enable is low
    wire logic        wr_en       = bus_in.wr && ce_in;
    wire logic        rd_en       = bus_in.rd && ce_in;
    wire logic        wr_base     = wr_en && (bus_in.addr == vpn_pkg::OFF_VEC_BASE);
    wire logic        wr_prio2    = wr_en && (bus_in.addr == vpn_pkg::OFF_PRIO2);
    wire logic        wr_nctrl    = wr_en && (bus_in.addr == vpn_pkg::OFF_NCTRL);
    wire logic        wr_nstat    = wr_en && (bus_in.addr == vpn_pkg::OFF_NSTAT);
    wire logic        wr_fstat    = wr_en && (bus_in.addr == vpn_pkg::OFF_FSTAT);
    wire logic        rd_nvec     = rd_en && (bus_in.addr == vpn_pkg::OFF_NVEC);
    wire logic        rd_fvec     = rd_en && (bus_in.addr == vpn_pkg::OFF_FVEC);

    // nesting enables
    wire logic        nest_n      = nctrl_q[vpn_pkg::NEST_NORMAL_BIT];
    wire logic        nest_f      = nctrl_q[vpn_pkg::NEST_FAST_BIT];
    wire logic        no_nest     = !nest_n && !nest_f;

    // normal sources above 21 do not exist
    wire logic [27:0] irq_pend    = irq_pend_in & 28'h03f_ffff;

    // both status registers block; only applied where levels are honoured
    wire logic [7:0]  blk_all     = block_of(nstat_q | fstat_q);
    wire logic [7:0]  blk_n       = nest_n ? blk_all : 8'h00;
    wire logic [7:0]  blk_f       = nest_f ? blk_all : 8'h00;

    // effective level table: group two fields overlay the external levels
    logic [83:0] lvl_all;
    always_comb begin
        lvl_all = lvl_in;
        for (int k = 0; k < int'(vpn_pkg::NUM_PRIO2); k++) begin
            lvl_all[vpn_pkg::PRIO2_SRC[k]*3 +: 3] = prio2_q[vpn_pkg::PRIO2_LSB[k] +: 3];
        end
    end

    vpn_pkg::vpn_pick_s irq_pick;
    vpn_pkg::vpn_pick_s fiq_pick;

    // normal path search; levels ignored unless normal nesting is on
    vpn_prio_pick u_irq_pick (
        .pend_in    (irq_pend),
        .lvl_in     (lvl_all),
        .use_lvl_in (nest_n),
        .block_in   (blk_n),
        .pick_out   (irq_pick)
    );

    // fast path search
    vpn_prio_pick u_fiq_pick (
        .pend_in    (fiq_pend_in),
        .lvl_in     (lvl_all),
        .use_lvl_in (nest_f),
        .block_in   (blk_f),
        .pick_out   (fiq_pick)
    );

    // vector words, both built on the shared base
    wire logic [31:0] nvec_word   = mk_vec(base_q, irq_pick.src);
    wire logic [31:0] fvec_word   = mk_vec(base_q, fiq_pick.src);

    // a fast request masks the normal one when both nesting control bits are clear
    wire logic        irq_req_d   = irq_pick.valid && !(no_nest && fiq_pick.valid);
    wire logic        fiq_req_d   = fiq_pick.valid;

    // status next values: the set from a vector read wins over a same-cycle clear
    always_comb begin
        nstat_d = nstat_q;
        fstat_d = fstat_q;
        if (wr_nstat) begin
            nstat_d = clr_top(nstat_q);
        end
        if (wr_fstat) begin
            fstat_d = clr_top(fstat_q);
        end
        if (rd_nvec && nest_n && irq_pick.valid) begin
            nstat_d = nstat_d | lvl_bit(irq_pick.level);
        end
        if (rd_fvec && nest_f && fiq_pick.valid) begin
            fstat_d = fstat_d | lvl_bit(fiq_pick.level);
        end
    end

    // read decode; data stands only in the cycle after the strobe
    always_comb begin
        rdata_d = vpn_pkg::RD_UNMAP;
        if (!rd_en) begin
            rdata_d = vpn_pkg::RD_UNMAP;
        end else if (bus_in.addr == vpn_pkg::OFF_VEC_BASE) begin
            rdata_d = {16'h0000, base_q};
        end else if (bus_in.addr == vpn_pkg::OFF_NVEC) begin
            rdata_d = nvec_word;
        end else if (bus_in.addr == vpn_pkg::OFF_PRIO2) begin
            rdata_d = prio2_q;
        end else if (bus_in.addr == vpn_pkg::OFF_NCTRL) begin
            rdata_d = {30'h0000_0000, nctrl_q};
        end else if (bus_in.addr == vpn_pkg::OFF_NSTAT) begin
            rdata_d = {24'h00_0000, nstat_q};
        end else if (bus_in.addr == vpn_pkg::OFF_FVEC) begin
            rdata_d = fvec_word;
        end else if (bus_in.addr == vpn_pkg::OFF_FSTAT) begin
            rdata_d = {24'h00_0000, fstat_q};
        end
    end

    // software-written configuration; reserved bits are dropped so they read zero
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            base_q  <= 16'h0000;
            prio2_q <= vpn_pkg::RST_WORD;
            nctrl_q <= 2'h0;
        end else begin
            if (wr_base) begin
                base_q <= bus_in.wdata[15:0];
            end
            if (wr_prio2) begin
                prio2_q <= bus_in.wdata & vpn_pkg::PRIO2_MASK;
            end
            if (wr_nctrl) begin
                nctrl_q <= bus_in.wdata[1:0] & vpn_pkg::NCTRL_MASK;
            end
        end
    end

    // nesting status, read data and request outputs
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            nstat_q   <= 8'h00;
            fstat_q   <= 8'h00;
            rdata_q   <= vpn_pkg::RST_WORD;
            irq_req_q <= 1'b0;
            fiq_req_q <= 1'b0;
        end else if (ce_in) begin
            nstat_q   <= nstat_d;
            fstat_q   <= fstat_d;
            rdata_q   <= rdata_d;
            irq_req_q <= irq_req_d;
            fiq_req_q <= fiq_req_d;
        end
    end

    assign rdata_out   = rdata_q;
    assign irq_req_out = irq_req_q;
    assign fiq_req_out = fiq_req_q;

    // checks below watch only what this block drives
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    // a read of the fast vector with fast nesting on and a pending source
    sequence s_fvec_take;
        rd_fvec && nest_f && fiq_pick.valid;
    endsequence

    // a read of the normal vector with normal nesting on and a pending source
    sequence s_nvec_take;
        rd_nvec && nest_n && irq_pick.valid;
    endsequence

    // a write to a status register with no read beside it
    sequence s_nstat_clr;
        wr_nstat && !rd_en;
    endsequence

    sequence s_fstat_clr;
        wr_fstat && !rd_en;
    endsequence

    fvec_layout_a: assert property (
        rd_fvec |=> (rdata_out[31:23] == 9'h000) && (rdata_out[1:0] == 2'h0)
                    && (rdata_out[22:7] == $past(base_q)) && (rdata_out[6:2] == $past(fiq_pick.src)))
        else $error("fast vector word layout wrong");

    nvec_layout_a: assert property (
        rd_nvec |=> (rdata_out == {9'h000, $past(base_q), $past(irq_pick.src), 2'h0})
                    && (rdata_out[6:2] <= 5'h15))
        else $error("normal vector word wrong");

    nstat_set_a: assert property (
        s_nvec_take |=> nstat_q[$past(irq_pick.level)])
        else $error("normal status bit not set on vector read");

    fstat_set_a: assert property (
        s_fvec_take |=> fstat_q[$past(fiq_pick.level)])
        else $error("fast status bit not set on vector read");

    nstat_clr_a: assert property (
        s_nstat_clr |=> nstat_q == ($past(nstat_q) & ($past(nstat_q) - 8'h01)))
        else $error("normal status did not drop exactly its top bit");

    fstat_clr_a: assert property (
        s_fstat_clr |=> ((fstat_q & ~$past(fstat_q)) == 8'h00)
                        && ($countones($past(fstat_q) ^ fstat_q) == (($past(fstat_q) != 8'h00) ? 1 : 0))
                        && (((($past(fstat_q) ^ fstat_q) - 8'h01) & $past(fstat_q)) == 8'h00))
        else $error("fast status clear sequence wrong");

    no_nest_set_a: assert property (
        (rd_nvec && !nest_n && !wr_nstat) |=> $stable(nstat_q))
        else $error("normal status changed with nesting off");

    fiq_first_a: assert property (
        (ce_in && no_nest && fiq_pick.valid) |=> !irq_req_out && fiq_req_out)
        else $error("normal request not held back by fast request");

    blocked_level_a: assert property (
        (nest_n && irq_pick.valid) |-> !blk_all[irq_pick.level])
        else $error("normal pick at a blocked level");

    fast_block_a: assert property (
        (nest_f && (nstat_q[0] || fstat_q[0])) |-> !fiq_pick.valid)
        else $error("fast pick with level zero nested");

    ignore_level_a: assert property (
        (!nest_n && (irq_pend != 28'h000_0000)) |-> irq_pick.valid && irq_pick.level == 3'h0)
        else $error("levels not ignored with nesting off");

    prio2_read_a: assert property (
        wr_prio2 ##1 (bus_in.rd && ce_in && bus_in.addr == vpn_pkg::OFF_PRIO2)
            |=> rdata_out == ($past(bus_in.wdata, 2) & 32'h0077_7777))
        else $error("group two readback wrong");

    ce_freeze_a: assert property (
        !ce_in |=> $stable(nstat_q) && $stable(fstat_q) && $stable(rdata_out))
        else $error("state moved with clock enable low");

endmodule : vpn_nest_ctrl

// file: vpn_core_model.sv
// processor core stand-in: counts entries into normal and fast service
`timescale 1ns/10ps

module vpn_core_model (
    input  wire logic       clk_in,        // core clock
    input  wire logic       arst_n_in,     // asynchronous reset, active low
    input  wire logic       irq_req_in,    // normal request from the block
    input  wire logic       fiq_req_in,    // fast request from the block
    output logic [7:0]      irq_entry_out, // normal service entries seen
    output logic [7:0]      fiq_entry_out  // fast service entries seen
);
    logic irq_d1_q;
    logic fiq_d1_q;

    // an entry is a rising request; the core responds at once, never slower
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_d1_q      <= 1'b0;
            fiq_d1_q      <= 1'b0;
            irq_entry_out <= 8'h00;
            fiq_entry_out <= 8'h00;
        end else begin
            irq_d1_q      <= irq_req_in;
            fiq_d1_q      <= fiq_req_in;
            irq_entry_out <= irq_entry_out + 8'((irq_req_in && !irq_d1_q) ? 1 : 0);
            fiq_entry_out <= fiq_entry_out + 8'((fiq_req_in && !fiq_d1_q) ? 1 : 0);
        end
    end
endmodule : vpn_core_model

// file: tb_top.sv
// self-checking bench for the priority and nesting block
`timescale 1ns/10ps

module tb_top;
    localparam logic [31:0] MAP [8] = '{vpn_pkg::OFF_VEC_BASE, vpn_pkg::OFF_NVEC, vpn_pkg::OFF_PRIO2,
        vpn_pkg::OFF_NCTRL, vpn_pkg::OFF_NSTAT, vpn_pkg::OFF_FVEC, vpn_pkg::OFF_FSTAT, 32'hffff0040};
    logic                  clk_in;
    logic                  arst_n_in;
    logic                  ce_in;
    vpn_pkg::vpn_bus_req_s bus;
    logic [31:0]           rdata;
    logic [27:0]           irq_pend;
    logic [27:0]           fiq_pend;
    logic [83:0]           lvl;
    logic                  irq_req;
    logic                  fiq_req;
    logic [7:0]            irq_ent;
    logic [7:0]            fiq_ent;
    logic [31:0]           lfsr_q;
    logic [31:0]           g2;
    logic [15:0]           base;
    logic [31:0]           got;
    logic [27:0]           pv;
    logic [8:0]            pn;
    logic [8:0]            pf;
    int                    num_errors;
    int                    n_checks;

    vpn_nest_ctrl i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .bus_in(bus),
        .rdata_out(rdata), .irq_pend_in(irq_pend), .fiq_pend_in(fiq_pend), .lvl_in(lvl),
        .irq_req_out(irq_req), .fiq_req_out(fiq_req));
    vpn_core_model i_core (.clk_in(clk_in), .arst_n_in(arst_n_in), .irq_req_in(irq_req),
        .fiq_req_in(fiq_req), .irq_entry_out(irq_ent), .fiq_entry_out(fiq_ent));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // random draws; the whole run repeats from the fixed start value
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt

    // best unblocked source: lowest level, then lowest number; {valid, src, level}
    function automatic logic [8:0] pick(input logic [27:0] p, input logic [31:0] g, input logic [7:0] blk);
        logic [8:0] r;
        logic [2:0] v;
        logic [8:0] m;
        r = 9'h000;
        for (int i = 27; i >= 0; i--) begin
            v = (i >= 16 && i <= 21) ? g[4*(i-16) +: 3] : lvl[3*i +: 3];
            m = (9'h002 << v) - 9'h001;
            if (p[i] && (blk & m[7:0]) == 8'h00 && (!r[8] || v <= r[2:0])) r = {1'b1, 5'(i), v};
        end
        return r;
    endfunction : pick

    function automatic logic [31:0] vec(input logic [4:0] s);
        return {9'h000, base, s, 2'b00};
    endfunction : vec

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // pending change, then one edge for the registered requests
    task automatic put(input logic [27:0] ip, input logic [27:0] fp);
        @(posedge clk_in);
        irq_pend <= ip;
        fiq_pend <= fp;
        @(posedge clk_in);
        #1;
    endtask : put

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    // a hang cuts the run short well beyond the few hundred cycles needed
    initial begin
        #200000;
        num_errors++;
        test_done();
    end

    initial begin
        arst_n_in = 1'b0;
        ce_in = 1'b1;
        bus = '0;
        irq_pend = 28'h0;
        fiq_pend = 28'h0;
        lvl = '0;
        lfsr_q = 32'hb376c94d;
        num_errors = 0;
        n_checks = 0;
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'b1;
        foreach (MAP[i]) begin
            rd(MAP[i], got);
            chk("reset value", 32'h0, got);
        end
        lfsr_q = nxt(lfsr_q);
        g2 = lfsr_q & vpn_pkg::PRIO2_MASK;
        // write then read with no gap between the strobes
        @(posedge clk_in);
        bus <= '{addr: vpn_pkg::OFF_PRIO2, wdata: lfsr_q, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus <= '{addr: vpn_pkg::OFF_PRIO2, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus.rd <= 1'b0;
        #1 got = rdata;
        chk("group two", g2, got);
        base = lfsr_q[31:16];
        wr(vpn_pkg::OFF_VEC_BASE, {16'h0, base});
        rd(vpn_pkg::OFF_VEC_BASE, got);
        chk("vector base", {16'h0, base}, got);
        // strobes while frozen must leave the control register alone
        @(posedge clk_in);
        ce_in <= 1'b0;
        wr(vpn_pkg::OFF_NCTRL, 32'h3);
        ce_in <= 1'b1;
        rd(vpn_pkg::OFF_NCTRL, got);
        chk("frozen write", 32'h0, got);
        // nesting off: levels ignored, no status, fast beats normal
        lvl[14:12] <= 3'h3;
        lvl[29:27] <= 3'h5;
        put(28'h290, 28'h0);
        chk_bit("normal request", 1'b1, irq_req);
        rd(vpn_pkg::OFF_NVEC, got);
        chk("unprioritised vector", vec(5'd4), got);
        rd(vpn_pkg::OFF_NSTAT, got);
        chk("normal status", 32'h0, got);
        put(28'h290, 28'h010);
        chk_bit("normal request", 1'b0, irq_req);
        chk_bit("fast request", 1'b1, fiq_req);
        // nesting per path: set level 3 then nest level 0, clear one bit per write
        for (int p = 0; p < 2; p++) begin
            wr(vpn_pkg::OFF_NCTRL, p ? 32'h2 : 32'h1);
            pv = 28'h210;
            put(p ? 28'h0 : pv, p ? pv : 28'h0);
            rd(p ? vpn_pkg::OFF_FVEC : vpn_pkg::OFF_NVEC, got);
            chk("first vector", vec(5'd4), got);
            put(p ? 28'h0 : pv, p ? pv : 28'h0);
            chk_bit("blocked request", 1'b0, p ? fiq_req : irq_req);
            pv = 28'h290;
            put(p ? 28'h0 : pv, p ? pv : 28'h0);
            chk_bit("nested request", 1'b1, p ? fiq_req : irq_req);
            rd(p ? vpn_pkg::OFF_FVEC : vpn_pkg::OFF_NVEC, got);
            chk("nested vector", vec(5'd7), got);
            rd(p ? vpn_pkg::OFF_FSTAT : vpn_pkg::OFF_NSTAT, got);
            chk("status set", 32'h9, got);
            for (int k = 0; k < 2; k++) begin
                wr(p ? vpn_pkg::OFF_FSTAT : vpn_pkg::OFF_NSTAT, 32'hff);
                rd(p ? vpn_pkg::OFF_FSTAT : vpn_pkg::OFF_NSTAT, got);
                chk("status clear", k ? 32'h0 : 32'h8, got);
            end
            put(28'h0, 28'h0);
        end
        // random levels and pending sets with both paths nesting
        wr(vpn_pkg::OFF_NCTRL, 32'h3);
        for (int n = 0; n < 8; n++) begin
            lfsr_q = nxt(lfsr_q);
            lvl[31:0] <= lfsr_q;
            lfsr_q = nxt(lfsr_q);
            lvl[63:32] <= lfsr_q;
            lfsr_q = nxt(lfsr_q);
            lvl[83:64] <= lfsr_q[19:0];
            g2 = lfsr_q & vpn_pkg::PRIO2_MASK;
            wr(vpn_pkg::OFF_PRIO2, g2);
            lfsr_q = nxt(lfsr_q);
            put(lfsr_q[27:0], 28'(nxt(lfsr_q)));
            pn = pick(irq_pend & 28'h03fffff, g2, 8'h00);
            rd(vpn_pkg::OFF_NVEC, got);
            chk("normal vector", vec(pn[7:3]), got);
            pf = pick(fiq_pend, g2, pn[8] ? (8'h01 << pn[2:0]) : 8'h00);
            rd(vpn_pkg::OFF_FVEC, got);
            chk("fast vector", vec(pf[7:3]), got);
            rd(vpn_pkg::OFF_NSTAT, got);
            chk("normal status", pn[8] ? (32'h1 << pn[2:0]) : 32'h0, got);
            rd(vpn_pkg::OFF_FSTAT, got);
            chk("fast status", pf[8] ? (32'h1 << pf[2:0]) : 32'h0, got);
            wr(vpn_pkg::OFF_NSTAT, 32'hff);
            wr(vpn_pkg::OFF_FSTAT, 32'hff);
        end
        // the core stand-in must have entered both kinds of service at least once
        chk_bit("core normal entries", 1'b1, irq_ent != 8'h00);
        chk_bit("core fast entries", 1'b1, fiq_ent != 8'h00);
        test_done();
    end
endmodule : tb_top
